// file: rtl/clock_mux_gate.sv
// Purpose: sampled model of a 2-to-4 clock mux with a falling-edge gating latch
// Assumes: input clocks are slower than half the 40 MHz sampling clock
// Notes:   outputs lag the pins by the synchroniser plus one register stage
//
// What this block does
// - select low routes clock b, select high routes clock a
// - four output pairs all carry the same selected clock together
// - complement output is always the inverse of the true output
// - gate low forces true low, complement high, at next falling input edge
// - gate enable latched only on a fall of the muxed clock level; a select swap that takes that level from high to low also counts
// - gate latch resets enabled; synchronised pins reset low
`timescale 1ns/1ps
`default_nettype none
module clock_mux_gate (
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic                              ce,
  input  wire logic                              clkInA,
  input  wire logic                              clkInB,
  input  wire logic                              srcSel,
  input  wire logic                              gateEn,
  output logic      [clock_mux_pkg::PAIRS-1:0]   outTrue,
  output logic      [clock_mux_pkg::PAIRS-1:0]   outComp
);
  typedef struct packed {
    logic                            prevLevel;
    logic                            gateLatch;
    logic [clock_mux_pkg::PAIRS-1:0] trueOut;
    logic [clock_mux_pkg::PAIRS-1:0] compOut;
  } mux_state_t;

  mux_state_t                        s_q;
  mux_state_t                        s_d;
  logic [clock_mux_pkg::PINS-1:0]    pinsRaw;
  logic [clock_mux_pkg::PINS-1:0]    pinsS;
  logic                              curLevel;
  logic                              fallEdge;
  logic                              gateNext;
  logic                              syncClkA;
  logic                              syncClkB;
  logic                              syncSel;
  logic                              syncGate;

  // the select decode is shared by the clock path and its checks
  function automatic logic routesA(input logic sel);
    return sel == clock_mux_pkg::SEL_CLK_A;
  endfunction

  assign pinsRaw[clock_mux_pkg::PIN_CLK_A] = clkInA;
  assign pinsRaw[clock_mux_pkg::PIN_CLK_B] = clkInB;
  assign pinsRaw[clock_mux_pkg::PIN_SEL]   = srcSel;
  assign pinsRaw[clock_mux_pkg::PIN_GATE]  = gateEn;

  pin_sync syncPins (
    .clock   (clock),
    .reset   (reset),
    .ce      (ce),
    .pinsIn  (pinsRaw),
    .pinsOut (pinsS)
  );

  assign syncClkA = pinsS[clock_mux_pkg::PIN_CLK_A];
  assign syncClkB = pinsS[clock_mux_pkg::PIN_CLK_B];
  assign syncSel  = pinsS[clock_mux_pkg::PIN_SEL];
  assign syncGate = pinsS[clock_mux_pkg::PIN_GATE];

  // select is not aligned to either input clock, so a switch can cut a pulse short
  assign curLevel = routesA(syncSel) ? syncClkA : syncClkB;
  assign fallEdge = s_q.prevLevel & ~curLevel;
  assign gateNext = fallEdge ? pinsS[clock_mux_pkg::PIN_GATE] : s_q.gateLatch;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.prevLevel = curLevel;
      s_d.gateLatch = gateNext;
      // gating only lands while the selected clock is low, so no runt pulse
      s_d.trueOut   = gateNext ? {clock_mux_pkg::PAIRS{curLevel}}
                               : clock_mux_pkg::ALL_LOW;
      s_d.compOut   = ~s_d.trueOut;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q.prevLevel <= clock_mux_pkg::LEVEL_RESET;
      s_q.gateLatch <= clock_mux_pkg::GATE_RESET;
      s_q.trueOut   <= clock_mux_pkg::TRUE_RESET;
      s_q.compOut   <= clock_mux_pkg::COMP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign outTrue = s_q.trueOut;
  assign outComp = s_q.compOut;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  select_route_a: assert property (
    (ce && gateNext && routesA(syncSel))
      |=> outTrue[0] == $past(pinsS[clock_mux_pkg::PIN_CLK_A]))
    else $error("selected clock a not routed");

  select_b_a: assert property (
    (ce && gateNext && !routesA(syncSel))
      |=> outTrue[0] == $past(pinsS[clock_mux_pkg::PIN_CLK_B]))
    else $error("selected clock b not routed");

  pairs_same_a: assert property (
    outTrue == clock_mux_pkg::ALL_LOW || outTrue == clock_mux_pkg::ALL_HIGH)
    else $error("output pairs differ");

  comp_inverse_a: assert property (outComp == ~outTrue)
    else $error("complement not inverse of true");

  gate_force_a: assert property (
    (ce && fallEdge && !pinsS[clock_mux_pkg::PIN_GATE])
      |=> outTrue == clock_mux_pkg::ALL_LOW && outComp == clock_mux_pkg::ALL_HIGH
          && !s_q.gateLatch)
    else $error("gate low did not force outputs at falling edge");

  gate_wait_a: assert property (
    (ce && !fallEdge && s_q.gateLatch && curLevel)
      |=> outTrue == clock_mux_pkg::ALL_HIGH)
    else $error("gate acted before falling edge");

  latch_hold_a: assert property (
    (!ce || !fallEdge) |=> $stable(s_q.gateLatch))
    else $error("gate latch changed without falling edge");

  reset_enabled_a: assert property (
    @(posedge clock) $past(reset) && !reset |-> s_q.gateLatch)
    else $error("gate latch not enabled after reset");

  select_direct_a: assert property (
    (ce && !fallEdge && s_q.gateLatch && $changed(pinsS[clock_mux_pkg::PIN_SEL]))
      |=> outTrue[0] == $past(curLevel))
    else $error("select change not applied directly");

  // reset itself must be watched, so this one carries its own disable
  reset_values_a: assert property (
    @(posedge clock) disable iff (1'b0)
    reset |-> outTrue == clock_mux_pkg::TRUE_RESET && outComp == clock_mux_pkg::COMP_RESET
              && s_q.gateLatch == clock_mux_pkg::GATE_RESET)
    else $error("reset values not applied");

  disabled_low_a: assert property (
    !s_q.gateLatch |-> outTrue == clock_mux_pkg::ALL_LOW && outComp == clock_mux_pkg::ALL_HIGH)
    else $error("outputs not parked while gate latch closed");

  fall_low_a: assert property (
    (ce && fallEdge) |=> outTrue == clock_mux_pkg::ALL_LOW)
    else $error("output not low after falling edge");

  gated_stays_a: assert property (
    (ce && !gateNext) |=> outTrue == clock_mux_pkg::ALL_LOW && outComp == clock_mux_pkg::ALL_HIGH)
    else $error("closed gate let the clock through");

  comp_follow_a: assert property (
    (ce && gateNext) |=> outComp == ($past(curLevel) ? clock_mux_pkg::ALL_LOW : clock_mux_pkg::ALL_HIGH))
    else $error("complement does not show inverse of selected clock");

  reenable_wait_a: assert property (
    (ce && !fallEdge && !s_q.gateLatch)
      |=> outTrue == clock_mux_pkg::ALL_LOW && !s_q.gateLatch)
    else $error("outputs re-enabled before falling edge");

  reenable_fall_a: assert property (
    (ce && fallEdge && syncGate) |=> s_q.gateLatch)
    else $error("gate latch not opened at falling edge");

  gate_ignored_a: assert property (
    (ce && !fallEdge && syncGate != s_q.gateLatch)
      |=> s_q.gateLatch == $past(s_q.gateLatch))
    else $error("gate change taken without falling edge");

  // opening only on a fall means the first pulse after re-enable is whole
  reenable_clean_a: assert property (
    $rose(s_q.gateLatch) |-> outTrue == clock_mux_pkg::ALL_LOW)
    else $error("re-enable landed while clock high");

  disable_clean_a: assert property (
    $fell(s_q.gateLatch) |-> outTrue == clock_mux_pkg::ALL_LOW && outComp == clock_mux_pkg::ALL_HIGH)
    else $error("disable landed while clock high");

  rise_enabled_a: assert property (
    $rose(outTrue[0]) |-> s_q.gateLatch)
    else $error("output rose while gate closed");

  freeze_hold_a: assert property (
    !ce |=> $stable(outTrue) && $stable(outComp)
            && $stable(s_q.prevLevel))
    else $error("state moved while clock enable low");

  // one label per pair, so a single stuck pair shows by name
  for (genvar p = 0; p < clock_mux_pkg::PAIRS; p++) begin : pairChk
    pair_level_a: assert property (
      (ce && gateNext) |=> outTrue[p] == $past(curLevel))
      else $error("pair does not carry selected clock");

    pair_inverse_a: assert property (
      outComp[p] == ~outTrue[p])
      else $error("pair complement not inverse");
  end

  disable_cov: cover property (ce && fallEdge && !pinsS[clock_mux_pkg::PIN_GATE]);
  reenable_cov: cover property (ce && fallEdge && !s_q.gateLatch
                                && pinsS[clock_mux_pkg::PIN_GATE]);
  switch_cov: cover property (ce && $changed(pinsS[clock_mux_pkg::PIN_SEL]));
  parked_cov: cover property (!s_q.gateLatch && curLevel);
  freeze_cov: cover property (!ce && s_q.gateLatch);
endmodule
`default_nettype wire

// file: rtl/clock_mux_pkg.sv
// Purpose: shared constants for the two-to-four gated clock multiplexer
// Assumes: one sampling clock at 40 MHz, far faster than the muxed input clocks
// Notes:   pin bit positions index the synchroniser bus
`default_nettype none
package clock_mux_pkg;
  localparam int         PAIRS       = 4;
  localparam int         PINS        = 4;
  localparam int         PIN_CLK_A   = 0;
  localparam int         PIN_CLK_B   = 1;
  localparam int         PIN_SEL     = 2;
  localparam int         PIN_GATE    = 3;
  localparam logic       SEL_CLK_A   = 1'b1;
  localparam logic       GATE_RESET  = 1'b1;
  localparam logic       LEVEL_RESET = 1'b0;
  localparam logic [3:0] SYNC_RESET  = 4'h0;
  localparam logic [3:0] TRUE_RESET  = 4'h0;
  localparam logic [3:0] COMP_RESET  = 4'hF;
  localparam logic [3:0] ALL_HIGH    = 4'hF;
  localparam logic [3:0] ALL_LOW     = 4'h0;
endpackage
`default_nettype wire

// file: rtl/pin_sync.sv
// Purpose: two flip-flop synchroniser for all asynchronous pins
// Assumes: pins are independent levels; no bus coherency needed
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic                             clock,
  input  wire logic                             reset,
  input  wire logic                             ce,
  input  wire logic [clock_mux_pkg::PINS-1:0]   pinsIn,
  output logic      [clock_mux_pkg::PINS-1:0]   pinsOut
);
  typedef struct packed {
    logic [clock_mux_pkg::PINS-1:0] stage1;
    logic [clock_mux_pkg::PINS-1:0] stage2;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.stage1 = pinsIn;
      s_d.stage2 = s_q.stage1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q.stage1 <= clock_mux_pkg::SYNC_RESET;
      s_q.stage2 <= clock_mux_pkg::SYNC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinsOut = s_q.stage2;
endmodule
`default_nettype wire

// file: sim/clock_sources.sv
// Purpose: free-running input clock sources for the mux
// Assumes: both far slower than the 40 MHz sampling clock
// Notes:   unrelated periods, so a wrong source choice shows
`timescale 1ns/1ps
`default_nettype none
module clock_sources #(
  parameter int HALF_A = 200,
  parameter int HALF_B = 330
) (
  output var logic clkInA,
  output var logic clkInB
);
  // input clocks run free; neither sits on a sampling edge
  // one process per clock, so each has a single driver
  initial begin
    clkInA = 1'b0;
    forever #(HALF_A) clkInA = ~clkInA;
  end
  initial begin
    clkInB = 1'b1;
    forever #(HALF_B) clkInB = ~clkInB;
  end
endmodule
`default_nettype wire

// file: sim/tb_two_to_four_clock_mux_sync_gate.sv
// Purpose: self-checking bench for the gated clock mux
// Assumes: pins reach the outputs two edges after they are sampled
// Notes:   a cycle model of mux and gate latch checks every edge
`timescale 1ns/1ps
`default_nettype none
module tb_two_to_four_clock_mux_sync_gate;
  logic       clock = 1'b0;
  logic       reset, ce, srcSel, gateEn, chkOn, lat;
  wire logic  clkInA, clkInB;
  logic [3:0] outTrue, outComp, hm, hg, held;
  int         failures, compares;
  wire logic  expLvl = lat & hm[2];
  clock_sources src (.clkInA(clkInA), .clkInB(clkInB));
  clock_mux_gate dut (.clock(clock), .reset(reset), .ce(ce), .clkInA(clkInA),
    .clkInB(clkInB), .srcSel(srcSel), .gateEn(gateEn), .outTrue(outTrue), .outComp(outComp));
  always #12.5 clock = ~clock;
  // model: falls are seen on the muxed level, so a select swap may count as one
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hm <= 4'h0;
      hg <= 4'hF;
      lat <= 1'b1;
    end else if (ce) begin
      if (hm[2] && !hm[1]) lat <= hg[1];
      hm <= {hm[2:0], srcSel ? clkInA : clkInB};
      hg <= {hg[2:0], gateEn};
    end
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t outputs %h, expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clock) if (chkOn === 1'b1) begin
    #2;
    check(outTrue, {4{expLvl}});
    check(outComp, ~{4{expLvl}});
  end
  task automatic run(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic test_select;
    srcSel = 1'b1;
    run(400);
    check(outTrue, {4{expLvl}});
    srcSel = 1'b0;
    run(400);
    check(outTrue, {4{expLvl}});
    $display("select test done");
  endtask
  task automatic test_gate;
    gateEn = 1'b0;
    run(200);
    check(outTrue, clock_mux_pkg::ALL_LOW);
    check(outComp, clock_mux_pkg::ALL_HIGH);
    gateEn = 1'b1;
    run(200);
    $display("gate test done");
  endtask
  task automatic test_freeze;
    ce = 1'b0;
    held = outTrue;
    run(30);
    check(outTrue, held);
    ce = 1'b1;
    run(50);
    $display("freeze test done");
  endtask
  task automatic test_reset;
    int waitCnt;
    gateEn = 1'b0;
    run(100);
    reset = 1'b1;
    run(2);
    check(outTrue, clock_mux_pkg::TRUE_RESET);
    check(outComp, clock_mux_pkg::COMP_RESET);
    gateEn = 1'b1;
    reset = 1'b0;
    waitCnt = 0;
    while (outTrue !== clock_mux_pkg::ALL_HIGH && waitCnt < 200) begin
      run(1);
      waitCnt++;
    end
    check(outTrue, clock_mux_pkg::ALL_HIGH);
    $display("reset test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    srcSel = 1'b1;
    gateEn = 1'b1;
    chkOn = 1'b0;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge clock);
    #1;
    reset = 1'b0;
    run(4);
    chkOn = 1'b1;
    test_select;
    test_gate;
    test_freeze;
    test_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
